// ==== rtl/rdr_pkg.sv ====
/*
  Shared constants and types of the redriver control block: strap levels, per-channel setting
  word, detect modes and states, register offsets, reset values and detect timing.
  Assumes a 125 MHz reference clock and five-level straps already resolved to a level code.
*/
package rdr_pkg;

  // ****************************************************************
  // Sizes and strap levels
  // ****************************************************************
  localparam int         CH_NUM  = 8;
  localparam int         BANK_CH = 4;
  localparam logic [2:0] LVL_L0  = 3'h0;
  localparam logic [2:0] LVL_L1  = 3'h1;
  localparam logic [2:0] LVL_L2  = 3'h2;
  localparam logic [2:0] LVL_L3  = 3'h3;
  localparam logic [2:0] LVL_L4  = 3'h4;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [2:0] bank0_boost_strap_low;
    logic [2:0] bank0_boost_strap_high;
    logic [2:0] bank1_boost_strap_low;
    logic [2:0] bank1_boost_strap_high;
    logic [2:0] bank0_level_strap;
    logic [2:0] bank1_level_strap;
    logic [2:0] termination_probe_strap;
  } rdr_strap_t;

  typedef struct packed {
    logic [3:0] first_boost_code;
    logic [2:0] second_boost_code;
    logic [3:0] midband_shape_code;
    logic       first_boost_skip;
    logic [2:0] flat_gain_code;
  } rdr_ch_cfg_t;

  typedef enum logic [1:0] {
    DM_OFF   = 2'b00,
    DM_THREE = 2'b01,
    DM_TWO   = 2'b10,
    DM_ONE   = 2'b11
  } rdr_det_mode_t;

  typedef enum logic [1:0] {
    DET_IDLE  = 2'b00,
    DET_WAIT  = 2'b01,
    DET_PROBE = 2'b10,
    DET_DONE  = 2'b11
  } rdr_det_st_t;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_CH_BASE = 8'h08;
  localparam int          CHF_CFG_LSB  = 0;
  localparam int          CHF_DM_LSB   = 16;
  localparam rdr_ch_cfg_t CFG_DEFAULT  = '{4'h0, 3'h0, 4'h0, 1'b1, 3'h5};
  localparam logic [2:0]  GAIN_DEFAULT = 3'h5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ      = 125;
  localparam int POLL_TIME_US = 150;
  localparam int POLL_CYC     = POLL_TIME_US * CLK_MHZ;
  localparam int PD_RESTART_US = 200;
  localparam int CAP_DELAY    = 2;

endpackage : rdr_pkg

// ==== rtl/rdr_ctrl.sv ====
/*
  Control logic of an eight-channel linear redriver: strap decode of boost and flat gain,
  per-channel register settings, receiver-detect machines, bank power-down and crosspoint select.
  Assumes straps, sideband pins and far-end detect results arrive asynchronously, and a
  simple register master on ref_clk.
*/
// Behaviour
// - Bank boost from its own strap pair
// - Register mode: per-channel boost setting
// - Profile settable only in register mode
// - Upper L0: codes 0,1,3, bypass set
// - Upper L1: codes 0-4, profiles 1,1,1,3,3
// - Upper L2: codes 5,6,8,10,10 table
// - Upper L3: codes 11-15, second 3-7
// - Bank gain from its own gain strap
// - Gain levels L0-L4 map to 0,1,3,7,5
// - Register mode: per-channel flat gain
// - Detect restarts at power-up, pd/select toggle
// - Detect strap L0: always 50 ohm
// - Strap L1: three detections then 50 ohm
// - Strap L2: two detections then 50 ohm
// - Float: poll every 150 us until found
// - Bank 0 power-down resets, Hi-Z termination
// - Bank 1 power-down resets, Hi-Z termination
// - Register mode: per-channel detect behaviour
// - Two selects drive straight or crossed paths
// - Detect enabled for L1, L2, float
// - Straps sampled once after power-up only
`timescale 1ns/1ps
module rdr_ctrl #(
  parameter int POLL_CYCLES = rdr_pkg::POLL_CYC
) (
  input  wire logic                              ref_clk,
  input  wire logic                              rstn,
  input  wire rdr_pkg::rdr_strap_t               strap_pins,
  input  wire logic                              bank0_powerdown_in,
  input  wire logic                              bank1_powerdown_in,
  input  wire logic                              crossover_select_a,
  input  wire logic                              crossover_select_b,
  input  wire logic [rdr_pkg::CH_NUM-1:0]        far_end_present,
  input  wire logic [7:0]                        reg_addr,
  input  wire logic [31:0]                       reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [31:0]                       reg_rdata_ff,
  output rdr_pkg::rdr_ch_cfg_t [rdr_pkg::CH_NUM-1:0] chan_cfg_ff,
  output logic      [rdr_pkg::CH_NUM-1:0]        term_50_ff,
  output logic      [rdr_pkg::CH_NUM-1:0]        path_reset_ff,
  output logic      [rdr_pkg::CH_NUM-1:0]        probe_ff,
  output logic      [1:0]                        crossover_ff
);

  localparam int CNT_W = $clog2(POLL_CYCLES + 1);

  // ****************************************************************
  // Decode functions
  // ****************************************************************
  function automatic rdr_pkg::rdr_ch_cfg_t eq_decode(input logic [2:0] hi, input logic [2:0] lo,
                                                     input logic [2:0] gain);
    rdr_pkg::rdr_ch_cfg_t c;
    logic [2:0] h;
    logic [2:0] l;
    c = rdr_pkg::CFG_DEFAULT;
    // Codes above L4 cannot come from a divider; they are read as floating.
    h = (hi > rdr_pkg::LVL_L4) ? rdr_pkg::LVL_L4 : hi;
    l = (lo > rdr_pkg::LVL_L4) ? rdr_pkg::LVL_L4 : lo;
    unique case ({h, l})
      {3'h0, 3'h0}: c = '{4'h0, 3'h0, 4'h0, 1'b1, 3'h0};
      {3'h0, 3'h1}: c = '{4'h1, 3'h0, 4'h0, 1'b1, 3'h0};
      {3'h0, 3'h2}: c = '{4'h3, 3'h0, 4'h0, 1'b1, 3'h0};
      {3'h1, 3'h0}: c = '{4'h0, 3'h0, 4'h1, 1'b0, 3'h0};
      {3'h1, 3'h1}: c = '{4'h1, 3'h0, 4'h1, 1'b0, 3'h0};
      {3'h1, 3'h2}: c = '{4'h2, 3'h0, 4'h1, 1'b0, 3'h0};
      {3'h1, 3'h3}: c = '{4'h3, 3'h0, 4'h3, 1'b0, 3'h0};
      {3'h1, 3'h4}: c = '{4'h4, 3'h0, 4'h3, 1'b0, 3'h0};
      {3'h2, 3'h0}: c = '{4'h5, 3'h1, 4'h7, 1'b0, 3'h0};
      {3'h2, 3'h1}: c = '{4'h6, 3'h1, 4'h7, 1'b0, 3'h0};
      {3'h2, 3'h2}: c = '{4'h8, 3'h1, 4'h7, 1'b0, 3'h0};
      {3'h2, 3'h3}: c = '{4'ha, 3'h1, 4'h7, 1'b0, 3'h0};
      {3'h2, 3'h4}: c = '{4'ha, 3'h2, 4'hf, 1'b0, 3'h0};
      {3'h3, 3'h0}: c = '{4'hb, 3'h3, 4'hf, 1'b0, 3'h0};
      {3'h3, 3'h1}: c = '{4'hc, 3'h4, 4'hf, 1'b0, 3'h0};
      {3'h3, 3'h2}: c = '{4'hd, 3'h5, 4'hf, 1'b0, 3'h0};
      {3'h3, 3'h3}: c = '{4'he, 3'h6, 4'hf, 1'b0, 3'h0};
      {3'h3, 3'h4}: c = '{4'hf, 3'h7, 4'hf, 1'b0, 3'h0};
      default:      c = rdr_pkg::CFG_DEFAULT;
    endcase
    // Strap settings keep the fixed trace-matched profile of the table above.
    c.flat_gain_code = gain_decode(gain);
    return c;
  endfunction : eq_decode

  function automatic logic [2:0] gain_decode(input logic [2:0] lvl);
    logic [2:0] g;
    g = rdr_pkg::GAIN_DEFAULT;
    unique case (lvl)
      rdr_pkg::LVL_L0: g = 3'h0;
      rdr_pkg::LVL_L1: g = 3'h1;
      rdr_pkg::LVL_L2: g = 3'h3;
      rdr_pkg::LVL_L3: g = 3'h7;
      default:         g = 3'h5;
    endcase
    return g;
  endfunction : gain_decode

  function automatic rdr_pkg::rdr_det_mode_t dm_decode(input logic [2:0] lvl);
    rdr_pkg::rdr_det_mode_t m;
    m = rdr_pkg::DM_ONE;
    unique case (lvl)
      rdr_pkg::LVL_L0: m = rdr_pkg::DM_OFF;
      rdr_pkg::LVL_L1: m = rdr_pkg::DM_THREE;
      rdr_pkg::LVL_L2: m = rdr_pkg::DM_TWO;
      // The reserved level behaves as floating so the link still comes up.
      default:         m = rdr_pkg::DM_ONE;
    endcase
    return m;
  endfunction : dm_decode

  function automatic logic [1:0] dm_need(input rdr_pkg::rdr_det_mode_t m);
    return (m == rdr_pkg::DM_THREE) ? 2'h3 : ((m == rdr_pkg::DM_TWO) ? 2'h2 : 2'h1);
  endfunction : dm_need

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  rdr_pkg::rdr_strap_t        strap_s1_ff;
  rdr_pkg::rdr_strap_t        strap_s2_ff;
  logic [5:0]                 side_s1_ff;
  logic [5:0]                 side_s2_ff;
  logic [5:0]                 side_q_ff;
  logic [rdr_pkg::CH_NUM-1:0] far_s1_ff;
  logic [rdr_pkg::CH_NUM-1:0] far_s2_ff;
  logic [1:0]                 pd_s;
  logic [1:0]                 sel_s;
  logic [1:0]                 restart;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_s1_ff <= '0;
      strap_s2_ff <= '0;
      side_s1_ff  <= 6'h00;
      side_s2_ff  <= 6'h00;
      side_q_ff   <= 6'h00;
      far_s1_ff   <= '0;
      far_s2_ff   <= '0;
    end else begin
      strap_s1_ff <= strap_pins;
      strap_s2_ff <= strap_s1_ff;
      side_s1_ff  <= {2'b00, crossover_select_b, crossover_select_a,
                      bank1_powerdown_in, bank0_powerdown_in};
      side_s2_ff  <= side_s1_ff;
      side_q_ff   <= side_s2_ff;
      far_s1_ff   <= far_end_present;
      far_s2_ff   <= far_s1_ff;
    end
  end

  assign pd_s  = side_s2_ff[1:0];
  assign sel_s = side_s2_ff[3:2];
  // Release of a bank's power-down pin, or either edge of its select pin, restarts that bank's detection.
  assign restart = (side_s2_ff[1:0] ^ side_q_ff[1:0]) |
                   (side_s2_ff[3:2] ^ side_q_ff[3:2]);

  // ****************************************************************
  // Strap capture, once after reset release
  // ****************************************************************
  logic [1:0]                 cap_cnt_ff;
  logic                       cap_done_ff;
  rdr_pkg::rdr_ch_cfg_t [1:0] strap_cfg_ff;
  rdr_pkg::rdr_det_mode_t     strap_dm_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cap_cnt_ff   <= 2'h0;
      cap_done_ff  <= 1'b0;
      strap_cfg_ff <= {rdr_pkg::CFG_DEFAULT, rdr_pkg::CFG_DEFAULT};
      strap_dm_ff  <= rdr_pkg::DM_ONE;
    end else if (!cap_done_ff) begin
      // Wait for the synchronisers to fill, then latch for good.
      if (cap_cnt_ff == 2'(rdr_pkg::CAP_DELAY)) begin
        cap_done_ff     <= 1'b1;
        strap_cfg_ff[0] <= eq_decode(strap_s2_ff.bank0_boost_strap_high,
                                     strap_s2_ff.bank0_boost_strap_low,
                                     strap_s2_ff.bank0_level_strap);
        strap_cfg_ff[1] <= eq_decode(strap_s2_ff.bank1_boost_strap_high,
                                     strap_s2_ff.bank1_boost_strap_low,
                                     strap_s2_ff.bank1_level_strap);
        strap_dm_ff     <= dm_decode(strap_s2_ff.termination_probe_strap);
      end else begin
        cap_cnt_ff <= cap_cnt_ff + 2'h1;
      end
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic                   reg_mode_ff;
  rdr_pkg::rdr_ch_cfg_t   reg_cfg_ff [rdr_pkg::CH_NUM];
  rdr_pkg::rdr_det_mode_t reg_dm_ff  [rdr_pkg::CH_NUM];
  logic [31:0]            nxt_rdata;

  function automatic logic ch_hit(input logic [7:0] a, input int ch);
    return a == (rdr_pkg::ADDR_CH_BASE + 8'(ch * 4));
  endfunction : ch_hit

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_mode_ff <= 1'b0;
    end else if (reg_wr && reg_addr == rdr_pkg::ADDR_CTRL) begin
      reg_mode_ff <= reg_wdata[0];
    end
  end

  generate
    for (genvar r = 0; r < rdr_pkg::CH_NUM; r++) begin : g_reg
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          reg_cfg_ff[r] <= rdr_pkg::CFG_DEFAULT;
          reg_dm_ff[r]  <= rdr_pkg::DM_ONE;
        end else if (reg_wr && ch_hit(reg_addr, r)) begin
          reg_cfg_ff[r] <= rdr_pkg::rdr_ch_cfg_t'(reg_wdata[rdr_pkg::CHF_CFG_LSB +: 15]);
          reg_dm_ff[r]  <= rdr_pkg::rdr_det_mode_t'(reg_wdata[rdr_pkg::CHF_DM_LSB +: 2]);
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_addr == rdr_pkg::ADDR_CTRL) begin
      nxt_rdata = {31'h0, reg_mode_ff};
    end else if (reg_addr == rdr_pkg::ADDR_STATUS) begin
      nxt_rdata = {24'h0, term_50_ff};
    end else begin
      for (int k = 0; k < rdr_pkg::CH_NUM; k++) begin
        if (ch_hit(reg_addr, k)) begin
          nxt_rdata = {14'h0, reg_dm_ff[k], 1'b0, reg_cfg_ff[k]};
        end
      end
    end
  end

  // Read data stand for exactly the cycle after the read strobe.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Receiver-detect machines and channel outputs
  // ****************************************************************
  rdr_pkg::rdr_det_st_t   st_ff   [rdr_pkg::CH_NUM];
  logic [CNT_W-1:0]       cnt_ff  [rdr_pkg::CH_NUM];
  logic [1:0]             hits_ff [rdr_pkg::CH_NUM];
  rdr_pkg::rdr_det_mode_t dm_eff  [rdr_pkg::CH_NUM];

  generate
    for (genvar i = 0; i < rdr_pkg::CH_NUM; i++) begin : g_ch
      localparam int B = i / rdr_pkg::BANK_CH;
      logic       poll_end;
      logic [1:0] nxt_hits;

      assign dm_eff[i] = reg_mode_ff ? reg_dm_ff[i] : strap_dm_ff;
      assign poll_end  = (cnt_ff[i] == CNT_W'(POLL_CYCLES - 1));
      assign nxt_hits  = hits_ff[i] + 2'h1;

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          st_ff[i]   <= rdr_pkg::DET_IDLE;
          cnt_ff[i]  <= '0;
          hits_ff[i] <= 2'h0;
        end else if (pd_s[B]) begin
          st_ff[i]   <= rdr_pkg::DET_IDLE;
          cnt_ff[i]  <= '0;
          hits_ff[i] <= 2'h0;
        end else if (restart[B]) begin
          st_ff[i]   <= rdr_pkg::DET_WAIT;
          cnt_ff[i]  <= '0;
          hits_ff[i] <= 2'h0;
        end else begin
          unique case (st_ff[i])
            rdr_pkg::DET_IDLE: begin
              if (cap_done_ff) begin
                st_ff[i] <= rdr_pkg::DET_WAIT;
              end
            end
            rdr_pkg::DET_WAIT: begin
              if (dm_eff[i] != rdr_pkg::DM_OFF && poll_end) begin
                st_ff[i]  <= rdr_pkg::DET_PROBE;
                cnt_ff[i] <= '0;
              end else if (!poll_end) begin
                cnt_ff[i] <= cnt_ff[i] + CNT_W'(1);
              end
            end
            rdr_pkg::DET_PROBE: begin
              // Any miss clears the run, so only back-to-back detections count.
              if (far_s2_ff[i]) begin
                hits_ff[i] <= nxt_hits;
                st_ff[i]   <= (nxt_hits >= dm_need(dm_eff[i])) ?
                              rdr_pkg::DET_DONE : rdr_pkg::DET_WAIT;
              end else begin
                hits_ff[i] <= 2'h0;
                st_ff[i]   <= rdr_pkg::DET_WAIT;
              end
            end
            rdr_pkg::DET_DONE: begin
              st_ff[i] <= rdr_pkg::DET_DONE;
            end
          endcase
        end
      end

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          term_50_ff[i]    <= 1'b0;
          path_reset_ff[i] <= 1'b1;
          probe_ff[i]      <= 1'b0;
          chan_cfg_ff[i]   <= rdr_pkg::CFG_DEFAULT;
        end else begin
          term_50_ff[i]    <= !pd_s[B] && (dm_eff[i] == rdr_pkg::DM_OFF ||
                                           st_ff[i] == rdr_pkg::DET_DONE);
          path_reset_ff[i] <= pd_s[B];
          probe_ff[i]      <= !pd_s[B] && !restart[B] && poll_end &&
                              st_ff[i] == rdr_pkg::DET_WAIT &&
                              dm_eff[i] != rdr_pkg::DM_OFF;
          chan_cfg_ff[i]   <= reg_mode_ff ? reg_cfg_ff[i] : strap_cfg_ff[B];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      crossover_ff <= 2'b00;
    end else begin
      crossover_ff <= sel_s;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  off_term_a: assert property ((dm_eff[0] == rdr_pkg::DM_OFF && !pd_s[0]) |=> term_50_ff[0])
    else $error("channel 0 not terminated in detect-off mode");
  pd0_hiz_a: assert property (pd_s[0] |=> (term_50_ff[3:0] == 4'h0 && path_reset_ff[3:0] == 4'hf))
    else $error("bank 0 power-down did not reset and release termination");
  pd1_hiz_a: assert property (pd_s[1] && !pd_s[0] |=> (term_50_ff[7:4] == 4'h0 && path_reset_ff[3:0] == 4'h0))
    else $error("bank 1 power-down wrong or leaked into bank 0");
  three_hits_a: assert property (($rose(st_ff[0] == rdr_pkg::DET_DONE) && dm_eff[0] == rdr_pkg::DM_THREE) |-> hits_ff[0] == 2'h3)
    else $error("three-detection mode finished early");
  two_hits_a: assert property (($rose(st_ff[0] == rdr_pkg::DET_DONE) && dm_eff[0] == rdr_pkg::DM_TWO) |-> hits_ff[0] == 2'h2)
    else $error("two-detection mode finished with wrong count");
  poll_gap_a: assert property ($rose(st_ff[0] == rdr_pkg::DET_PROBE) |-> ($past(cnt_ff[0]) == CNT_W'(POLL_CYCLES - 1) && probe_ff[0]))
    else $error("probe issued off the poll interval");
  strap_hold_a: assert property ((cap_done_ff && $past(cap_done_ff)) |-> $stable(strap_cfg_ff) && $stable(strap_dm_ff))
    else $error("strap settings changed after capture");
  restart_a: assert property ((restart[0] && !pd_s[0]) |=> st_ff[0] == rdr_pkg::DET_WAIT ##1 !term_50_ff[0] || dm_eff[0] == rdr_pkg::DM_OFF)
    else $error("select or power-down toggle did not restart detection");
  bypass_a: assert property ((!reg_mode_ff && cap_done_ff) |=> chan_cfg_ff[1].first_boost_skip == strap_cfg_ff[0].first_boost_skip)
    else $error("bank 0 channel not following bank strap setting");
  reg_cfg_a: assert property (reg_mode_ff |=> chan_cfg_ff[5] == $past(reg_cfg_ff[5]))
    else $error("register mode setting not applied to channel");
  cross_a: assert property (##1 crossover_ff == $past(sel_s))
    else $error("crosspoint select not followed");

  done_c:  cover property ($rose(term_50_ff[0]) && dm_eff[0] == rdr_pkg::DM_THREE);
  regw_c:  cover property (reg_mode_ff && reg_wr && ch_hit(reg_addr, 2));
  pd_c:    cover property ($rose(pd_s[1]) ##[1:20] $fell(pd_s[1]));
  miss_c:  cover property (st_ff[0] == rdr_pkg::DET_PROBE && !far_s2_ff[0] && hits_ff[0] != 2'h0);

endmodule : rdr_ctrl

// ==== dv/rdr_far_end.sv ====
/* Far-end receiver model: per-channel termination level and a count of channel-0 probes.
   Assumes probe pulses last one ref_clk cycle and that present is driven by the bench. */
`timescale 1ns/1ps
module rdr_far_end (
  input  wire logic [7:0] present,
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] probe,
  output logic      [7:0] far_end_present,
  output int              probe_cnt
);
  // An absent receiver has no termination, so its line reads low, never a held last level.
  assign far_end_present = present;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      probe_cnt <= 0;
    end else begin
      probe_cnt <= probe_cnt + 32'(probe[0]);
    end
  end
endmodule : rdr_far_end

// ==== dv/rdr_ctrl_bench.sv ====
/* Bench of rdr_ctrl: strap decode, register port, detect, power-down and crosspoint.
   Assumes rdr_far_end as far-end receiver and a poll interval cut to POLL cycles. */
`timescale 1ns/1ps
module rdr_ctrl_bench;
  localparam int POLL = 20;
  typedef struct packed {logic [2:0] hi, lo, g; rdr_pkg::rdr_ch_cfg_t cfg;} rdr_row_t;
  // Rows 2 and 9 are reserved boost pairs that must fall back to the index-0 set.
  localparam rdr_row_t ROWS [10] = '{
    '{3'h0, 3'h0, 3'h0, 15'h0008}, '{3'h0, 3'h2, 3'h1, 15'h1809},
    '{3'h0, 3'h3, 3'h2, 15'h000b}, '{3'h1, 3'h3, 3'h3, 15'h1837},
    '{3'h1, 3'h4, 3'h4, 15'h2035}, '{3'h2, 3'h2, 3'h0, 15'h4170},
    '{3'h2, 3'h4, 3'h1, 15'h52f1}, '{3'h3, 3'h0, 3'h2, 15'h5bf3},
    '{3'h3, 3'h4, 3'h3, 15'h7ff7}, '{3'h0, 3'h4, 3'h4, 15'h000d}};
  localparam logic [2:0] DETS [3] = '{3'h1, 3'h2, 3'h4};
  localparam int         HITS [3] = '{3, 2, 1};
  logic                       ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic                       bank0_powerdown_in = 1'b0, bank1_powerdown_in = 1'b0;
  logic                       crossover_select_a = 1'b0, crossover_select_b = 1'b0;
  logic [7:0]                 present = 8'h00, reg_addr = 8'h00, term_50_ff, path_reset_ff;
  logic [7:0]                 probe_ff, far_end_present;
  logic [31:0]                reg_wdata = 32'h0, reg_rdata_ff, d;
  logic [1:0]                 crossover_ff;
  rdr_pkg::rdr_strap_t        strap_pins = '0;
  rdr_pkg::rdr_ch_cfg_t [7:0] chan_cfg_ff;
  int                         probe_cnt, n, n_mismatch = 0, compares = 0;
  always #4 ref_clk = ~ref_clk;
  rdr_ctrl #(.POLL_CYCLES(POLL)) dut_u (.ref_clk, .rstn, .strap_pins, .bank0_powerdown_in,
    .bank1_powerdown_in, .crossover_select_a, .crossover_select_b, .far_end_present,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .chan_cfg_ff, .term_50_ff,
    .path_reset_ff, .probe_ff, .crossover_ff);
  rdr_far_end far_u (.present, .ref_clk, .rstn, .probe(probe_ff), .far_end_present, .probe_cnt);
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic do_reset(input int k);
    rstn <= 1'b0;
    cyc(k);
    rstn <= 1'b1;
    cyc(8);
  endtask : do_reset
  // Read data stand only in the cycle after the strobe, so they are taken 1 ns into it.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    {reg_wr, reg_rd} <= {w, !w};
    cyc(1);
    {reg_wr, reg_rd} <= 2'b00;
    #1 d = reg_rdata_ff;
    cyc(1);
  endtask : bus
  task automatic wait_term(input logic [7:0] w);
    for (n = 0; term_50_ff !== w && n < 400; n++)
      cyc(1);
    chk("termination", 32'(w), 32'(term_50_ff));
  endtask : wait_term
  task automatic close_out();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial begin
    cyc(5000);
    n_mismatch++;
    close_out();
  end
  initial begin
    do_reset(16);
    foreach (ROWS[i]) begin
      strap_pins <= '{ROWS[i].lo, ROWS[i].hi, ROWS[9-i].lo, ROWS[9-i].hi, ROWS[i].g,
                      ROWS[9-i].g, rdr_pkg::LVL_L0};
      do_reset(2);
      chk("bank0 cfg", 32'(ROWS[i].cfg), 32'(chan_cfg_ff[3]));
      chk("bank1 cfg", 32'(ROWS[9-i].cfg), 32'(chan_cfg_ff[4]));
      chk("detect off", 32'hff, 32'(term_50_ff));
    end
    $display("test strap table ended");
    strap_pins.termination_probe_strap <= rdr_pkg::LVL_L4;
    do_reset(2);
    bus(1'b0, rdr_pkg::ADDR_CH_BASE + 8'h04, 32'h0);
    chk("ch1 reset word", 32'h0003000d, d);
    bus(1'b1, rdr_pkg::ADDR_CTRL, 32'h1);
    bus(1'b1, rdr_pkg::ADDR_CH_BASE, 32'h00004a61);
    bus(1'b1, rdr_pkg::ADDR_CH_BASE + 8'h04, 32'h00012537);
    bus(1'b1, rdr_pkg::ADDR_STATUS, 32'hff);
    bus(1'b0, rdr_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h1, d);
    bus(1'b0, 8'hfc, 32'h0);
    chk("unmapped", 32'h0, d);
    chk("ch0 cfg", 32'h4a61, 32'(chan_cfg_ff[0]));
    chk("ch1 cfg", 32'h2537, 32'(chan_cfg_ff[1]));
    bus(1'b1, rdr_pkg::ADDR_CTRL, 32'h0);
    $display("test register port ended");
    present <= 8'hff;
    for (int k = 0; k < 3; k++) begin
      strap_pins.termination_probe_strap <= DETS[k];
      do_reset(2);
      chk("before detect", 32'h0, 32'(term_50_ff));
      wait_term(8'hff);
      chk("probe count", HITS[k], probe_cnt);
      chk("poll spacing", 32'h1, 32'(n >= HITS[k] * POLL - 8 && n < HITS[k] * (POLL + 4)));
    end
    strap_pins.termination_probe_strap <= rdr_pkg::LVL_L1;
    do_reset(2);
    for (n = 0; probe_cnt < 2 && n < 200; n++)
      cyc(1);
    present <= 8'hfe;
    for (n = 0; probe_cnt < 3 && n < 200; n++)
      cyc(1);
    present <= 8'hff;
    wait_term(8'hff);
    chk("hits after miss", 32'd6, probe_cnt);
    $display("test detect modes ended");
    for (int b = 0; b < 2; b++) begin
      // A short high pulse stands in for the long system restart pulse.
      {bank1_powerdown_in, bank0_powerdown_in} <= 2'(b + 1);
      cyc(8);
      chk("pd term", b ? 32'h0f : 32'hf0, 32'(term_50_ff));
      chk("pd path", b ? 32'hf0 : 32'h0f, 32'(path_reset_ff));
      {bank1_powerdown_in, bank0_powerdown_in} <= 2'b00;
      {crossover_select_b, crossover_select_a} <= 2'(b + 1);
      cyc(6);
      chk("crossover", 32'(b + 1), 32'(crossover_ff));
      chk("restart", b ? 32'h00 : 32'hf0, 32'(term_50_ff));
      wait_term(8'hff);
    end
    strap_pins.bank0_boost_strap_high <= rdr_pkg::LVL_L3;
    cyc(8);
    chk("late strap", 32'(ROWS[9].cfg), 32'(chan_cfg_ff[0]));
    $display("test power-down and crosspoint ended");
    close_out();
  end
endmodule : rdr_ctrl_bench
